// ### eew_pkg.sv
package eew_pkg;
    localparam logic [3:0] EEW_FIXED_NIBBLE = 4'ha;
    localparam int EEW_WORD_BITS = 8;
    localparam int EEW_ACK_BIT = 8;
    localparam int EEW_CLK_MHZ = 100;
    localparam int EEW_WR_MS_STD = 10;
    localparam int EEW_WR_MS_LOW = 20;
    localparam int EEW_WR_CYC_STD = EEW_WR_MS_STD * 1000 * EEW_CLK_MHZ;
    localparam int EEW_WR_CYC_LOW = EEW_WR_MS_LOW * 1000 * EEW_CLK_MHZ;
    localparam int EEW_MEM_AW = 13;
    localparam logic [1:0] EEW_UPPER_QUAD = 2'h3;
    typedef enum logic [2:0] {
        EEW_IDLE,
        EEW_ADDR,
        EEW_ACK,
        EEW_RX,
        EEW_TX,
        EEW_MACK
    } eew_state_e;
endpackage

// ### eew_sync.sv
`timescale 1ns/1ps
module eew_sync (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic din,
    output logic dout
);
    logic meta;
    logic next_meta;
    logic next_dout;

    always_comb begin
        next_meta = din;
        next_dout = meta;
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            meta <= 1'b1;
            dout <= 1'b1;
        end else begin
            meta <= next_meta;
            dout <= next_dout;
        end
    end
endmodule

// ### eew_front_end.sv
`timescale 1ns/1ps
module eew_front_end #(
    parameter int WR_CYCLES = eew_pkg::EEW_WR_CYC_STD
) (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic strap_select_bit2,
    input wire logic strap_select_bit1,
    input wire logic strap_select_bit0,
    input wire logic write_protect,
    input wire logic [7:0] tx_data,
    input wire logic upper_quadrant,
    output logic rx_valid,
    output logic [7:0] rx_data,
    output logic rx_first,
    output logic rx_refused,
    output logic tx_req,
    output logic read_mode,
    output logic standby,
    output logic write_busy
);
    import eew_pkg::*;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic scl_s;
    logic sda_s;
    logic scl_d;
    logic sda_d;

    eew_sync u_scl (.mclk(mclk), .rst_n(rst_n), .din(scl_in), .dout(scl_s));
    eew_sync u_sda (.mclk(mclk), .rst_n(rst_n), .din(sda_in), .dout(sda_s));

    // Level pins pass two flops as well
    logic [3:0] pin_raw;
    logic [3:0] pin_s;
    assign pin_raw = {write_protect, strap_select_bit2, strap_select_bit1, strap_select_bit0};
    for (genvar g = 0; g < 4; g++) begin : g_pin_sync
        eew_sync u_pin (.mclk(mclk), .rst_n(rst_n), .din(pin_raw[g]), .dout(pin_s[g]));
    end

    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_ev = scl_s & scl_d & sda_d & ~sda_s;
    assign stop_ev = scl_s & scl_d & ~sda_d & sda_s;

    // ****************************************
    // Protocol state
    // ****************************************
    eew_state_e state;
    eew_state_e next_state;
    logic [3:0] bitcnt;
    logic [3:0] next_bitcnt;
    logic [7:0] shreg;
    logic [7:0] next_shreg;
    logic ack_drive;
    logic next_ack_drive;
    logic tx_low;
    logic next_tx_low;
    logic rd;
    logic next_rd;
    logic first;
    logic next_first;
    logic wrote;
    logic next_wrote;
    logic nack_seen;
    logic next_nack_seen;
    logic [$clog2(WR_CYCLES+1)-1:0] wr_cnt;
    logic [$clog2(WR_CYCLES+1)-1:0] next_wr_cnt;
    logic next_rx_valid;
    logic [7:0] next_rx_data;
    logic next_rx_first;
    logic next_rx_refused;
    logic next_tx_req;
    logic next_standby;
    logic [7:0] addr_word;
    logic addr_match;
    logic protect_hit;

    // Strap pins are pulled low in the pad when left open
    assign addr_word = {shreg[6:0], sda_s};
    assign addr_match = (addr_word[7:4] == EEW_FIXED_NIBBLE) &&
        (addr_word[3:1] == pin_s[2:0]);
    assign protect_hit = pin_s[3] & upper_quadrant;

    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_shreg = shreg;
        next_ack_drive = ack_drive;
        next_tx_low = tx_low;
        next_rd = rd;
        next_first = first;
        next_wrote = wrote;
        next_nack_seen = nack_seen;
        next_wr_cnt = wr_cnt;
        next_rx_valid = 1'b0;
        next_rx_data = rx_data;
        next_rx_first = rx_first;
        next_rx_refused = rx_refused;
        next_tx_req = 1'b0;
        next_standby = standby;
        if (wr_cnt != '0) begin
            next_wr_cnt = wr_cnt - 1'b1;
            if (wr_cnt == 1) begin
                next_standby = 1'b1;
            end
        end
        if (stop_ev) begin
            next_state = EEW_IDLE;
            next_ack_drive = 1'b0;
            next_tx_low = 1'b0;
            if (wrote && wr_cnt == '0) begin
                next_wr_cnt = WR_CYCLES[$bits(wr_cnt)-1:0];
                next_standby = 1'b0;
            end else if (wr_cnt == '0) begin
                next_standby = 1'b1;
            end
            next_wrote = 1'b0;
        end else if (start_ev) begin
            // Inputs stay deaf during the internal write
            if (wr_cnt == '0) begin
                next_state = EEW_ADDR;
                next_standby = 1'b0;
            end
            next_bitcnt = '0;
            next_ack_drive = 1'b0;
            next_tx_low = 1'b0;
            next_wrote = 1'b0;
        end else begin
            case (state)
                EEW_IDLE: begin
                    next_bitcnt = '0;
                end
                EEW_ADDR, EEW_RX: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], sda_s};
                        next_bitcnt = bitcnt + 1'b1;
                        if (bitcnt == 4'(EEW_WORD_BITS - 1)) begin
                            next_bitcnt = '0;
                            if (state == EEW_ADDR) begin
                                if (addr_match) begin
                                    next_state = EEW_ACK;
                                    next_rd = addr_word[0];
                                    next_first = 1'b1;
                                end else begin
                                    next_state = EEW_IDLE;
                                    next_standby = 1'b1;
                                end
                            end else begin
                                next_state = EEW_ACK;
                                next_rx_valid = 1'b1;
                                next_rx_data = addr_word;
                                next_rx_first = first;
                                next_rx_refused = protect_hit;
                                next_first = 1'b0;
                                next_wrote = wrote | ~protect_hit;
                            end
                        end
                    end
                end
                EEW_ACK: begin
                    // Pull low across the whole ninth clock
                    if (scl_fall && !ack_drive) begin
                        next_ack_drive = 1'b1;
                    end else if (scl_fall && ack_drive) begin
                        next_ack_drive = 1'b0;
                        if (rd) begin
                            next_state = EEW_TX;
                            next_shreg = tx_data;
                            next_tx_req = 1'b1;
                            next_tx_low = ~tx_data[7];
                            next_bitcnt = '0;
                        end else begin
                            next_state = EEW_RX;
                        end
                    end
                end
                EEW_TX: begin
                    if (scl_fall) begin
                        next_bitcnt = bitcnt + 1'b1;
                        next_shreg = {shreg[6:0], 1'b1};
                        if (bitcnt == 4'(EEW_WORD_BITS - 1)) begin
                            next_state = EEW_MACK;
                            next_tx_low = 1'b0;
                        end else begin
                            next_tx_low = ~shreg[6];
                        end
                    end
                end
                EEW_MACK: begin
                    if (scl_rise) begin
                        next_nack_seen = sda_s;
                    end else if (scl_fall) begin
                        next_bitcnt = '0;
                        if (nack_seen) begin
                            next_state = EEW_IDLE;
                        end else begin
                            next_state = EEW_TX;
                            next_shreg = tx_data;
                            next_tx_req = 1'b1;
                            next_tx_low = ~tx_data[7];
                        end
                    end
                end
                default: begin
                    next_state = EEW_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            state <= EEW_IDLE;
            bitcnt <= '0;
            shreg <= '0;
            ack_drive <= 1'b0;
            tx_low <= 1'b0;
            rd <= 1'b0;
            first <= 1'b0;
            wrote <= 1'b0;
            nack_seen <= 1'b0;
            wr_cnt <= '0;
            rx_valid <= 1'b0;
            rx_data <= '0;
            rx_first <= 1'b0;
            rx_refused <= 1'b0;
            tx_req <= 1'b0;
            standby <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            shreg <= next_shreg;
            ack_drive <= next_ack_drive;
            tx_low <= next_tx_low;
            rd <= next_rd;
            first <= next_first;
            wrote <= next_wrote;
            nack_seen <= next_nack_seen;
            wr_cnt <= next_wr_cnt;
            rx_valid <= next_rx_valid;
            rx_data <= next_rx_data;
            rx_first <= next_rx_first;
            rx_refused <= next_rx_refused;
            tx_req <= next_tx_req;
            standby <= next_standby;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ****************************************
    // Open-drain data pin
    // ****************************************
    assign sda_out = 1'b0;
    assign sda_oe = ack_drive | tx_low;
    assign read_mode = rd;
    assign write_busy = (wr_cnt != '0);

    // ****************************************
    // Checks
    // ****************************************
    a_oe_only_ack_tx: assert property (@(posedge mclk) disable iff (!rst_n)
        sda_oe |-> (state == EEW_ACK || state == EEW_TX))
        else $error("Data line driven outside ack or data");
    a_start_to_addr: assert property (@(posedge mclk) disable iff (!rst_n)
        (start_ev && !stop_ev && wr_cnt == '0) |=> state == EEW_ADDR)
        else $error("Start not taken");
    a_stop_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        stop_ev |=> state == EEW_IDLE && !sda_oe)
        else $error("Stop did not return to idle");
    a_ack_drive_low: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == EEW_ACK && scl_fall && !ack_drive && !start_ev && !stop_ev) |=> sda_oe)
        else $error("No acknowledge on ninth clock");
    a_match_ack: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == EEW_ADDR && scl_rise && bitcnt == 4'h7 && addr_match
            && !start_ev && !stop_ev) |=> state == EEW_ACK)
        else $error("Matching address not acknowledged");
    a_mismatch_idle: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == EEW_ADDR && scl_rise && bitcnt == 4'h7 && !addr_match
            && !start_ev && !stop_ev) |=> state == EEW_IDLE && standby)
        else $error("Mismatched address not dropped");
    a_dir_bit: assert property (@(posedge mclk) disable iff (!rst_n)
        (state == EEW_ADDR && scl_rise && bitcnt == 4'h7 && addr_match
            && !start_ev && !stop_ev) |=> rd == $past(sda_s))
        else $error("Direction bit not taken");
    a_protect: assert property (@(posedge mclk) disable iff (!rst_n)
        (rx_valid && $past(pin_s[3]) && $past(upper_quadrant)) |-> rx_refused)
        else $error("Protected write not refused");
    a_write_busy: assert property (@(posedge mclk) disable iff (!rst_n)
        $rose(write_busy) |-> wr_cnt == WR_CYCLES[$bits(wr_cnt)-1:0])
        else $error("Write timer loaded wrongly");
    a_stop_standby: assert property (@(posedge mclk) disable iff (!rst_n)
        (stop_ev && !wrote && wr_cnt == '0) |=> standby)
        else $error("Stop did not enter standby");
endmodule

// ### eew_bus_master.sv
`timescale 1ns/1ps
module eew_bus_master (
    input wire logic mclk,
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // ****************
    // Bus master tasks
    // ****************
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic bit_cycle(input logic b, output logic seen);
        tick(2);
        sda_low <= ~b;
        tick(6);
        scl <= 1'b1;
        tick(4);
        seen = sda;
        tick(4);
        scl <= 1'b0;
    endtask
    task automatic start_cond();
        tick(2);
        sda_low <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b1;
        tick(8);
        scl <= 1'b0;
    endtask
    task automatic stop_cond();
        tick(2);
        sda_low <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(8);
        sda_low <= 1'b0;
        tick(16);
    endtask
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(d[i], s);
        end
        bit_cycle(1'b1, s);
        ack = ~s;
    endtask
    task automatic recv_byte(input logic mack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(1'b1, d[i]);
        end
        bit_cycle(~mack, s);
    endtask
    task automatic recover();
        logic s;
        s = 1'b0;
        for (int i = 0; i < 9 && s !== 1'b1; i++) begin
            bit_cycle(1'b1, s);
        end
        start_cond();
    endtask
endmodule

// ### test_eew_front_end.sv
`timescale 1ns/1ps
module test_eew_front_end;
    import eew_pkg::*;
    localparam int WR = 400;
    logic mclk, rst_n, scl, m_low, sda, s2, s1, s0, wp, uq;
    logic [7:0] txd, rx_data;
    logic sda_out, sda_oe, rx_valid, rx_first, rx_refused, tx_req, read_mode;
    logic standby, write_busy;
    logic [9:0] exp_q[$];
    logic [7:0] tx_q[$];
    int failures, check_count, cycles;
    // ***************
    // Bench structure
    // ***************
    assign sda = ~(m_low | (sda_oe & ~sda_out));
    eew_front_end #(.WR_CYCLES(WR)) u_eew_front_end (.mclk(mclk), .rst_n(rst_n),
        .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
        .strap_select_bit2(s2), .strap_select_bit1(s1), .strap_select_bit0(s0),
        .write_protect(wp), .tx_data(txd), .upper_quadrant(uq), .rx_valid(rx_valid),
        .rx_data(rx_data), .rx_first(rx_first), .rx_refused(rx_refused),
        .tx_req(tx_req), .read_mode(read_mode), .standby(standby),
        .write_busy(write_busy));
    eew_bus_master u_eew_bus_master (.mclk(mclk), .sda(sda), .scl(scl), .sda_low(m_low));
    always #5 mclk = ~mclk;
    task automatic check(input string what, input logic [9:0] e, input logic [9:0] g);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic addr_phase(input logic [7:0] a, input logic [2:0] ex);
        logic ack;
        u_eew_bus_master.start_cond();
        u_eew_bus_master.send_byte(a, ack);
        repeat (8) @(posedge mclk);
        check("addr", {7'h0, ex}, {7'h0, ack, standby, read_mode & ex[2]});
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (tx_req === 1'b1 && tx_q.size() > 0) begin
            void'(tx_q.pop_front());
        end
        txd <= (tx_q.size() > 0) ? tx_q[0] : 8'h00;
        if (rx_valid === 1'b1) begin
            check("rx_pending", 10'h1, {9'h0, exp_q.size() > 0});
            if (exp_q.size() > 0) begin
                check("rx_word", exp_q.pop_front(), {rx_first, rx_refused, rx_data});
            end
        end
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    // *********
    // Scenarios
    // *********
    initial begin
        logic ack, e;
        logic [7:0] a, d, s;
        logic [7:0] rd[3];
        int t0;
        mclk = 1'b0;
        rst_n = 1'b0;
        {s2, s1, s0} = 3'h0;
        wp = 1'b0;
        uq = 1'b0;
        s = 8'($urandom(32'ha923c1df));
        repeat (10) @(posedge mclk);
        check("reset", 10'h2, {8'h0, standby, sda_oe});
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 12; i++) begin
            s = 8'($urandom);
            a = 8'($urandom);
            if (i < 8) a[7:4] = EEW_FIXED_NIBBLE;
            if (i < 4) a[3:1] = s[2:0];
            a[0] = 1'b0;
            e = (a[7:4] == EEW_FIXED_NIBBLE) && (a[3:1] == s[2:0]);
            {s2, s1, s0} <= s[2:0];
            @(posedge mclk);
            addr_phase(a, {e, ~e, 1'b0});
            u_eew_bus_master.stop_cond();
        end
        $display("test address_match done");
        {s2, s1, s0} <= 3'h5;
        wp <= 1'b1;
        for (int p = 1; p >= 0; p--) begin
            uq <= p[0];
            addr_phase({EEW_FIXED_NIBBLE, 3'h5, 1'b0}, 3'b100);
            for (int k = 0; k < 3; k++) begin
                d = 8'($urandom);
                exp_q.push_back({k == 0, p[0], d});
                u_eew_bus_master.send_byte(d, ack);
                check("data_ack", 10'h1, {9'h0, ack});
            end
            u_eew_bus_master.stop_cond();
            t0 = cycles;
            check("busy", {9'h0, ~p[0]}, {9'h0, write_busy});
            check("rx_left", 10'h0, 10'(exp_q.size()));
        end
        addr_phase({EEW_FIXED_NIBBLE, 3'h5, 1'b0}, 3'b000);
        while (write_busy === 1'b1 && cycles - t0 < WR + 40) @(posedge mclk);
        check("write_end", 10'h1, {8'h0, write_busy, standby});
        check("write_len", 10'h1, {9'h0, cycles - t0 > WR - 40});
        $display("test write done");
        wp <= 1'b0;
        for (int k = 0; k < 3; k++) rd[k] = 8'($urandom);
        tx_q.push_back(rd[0]);
        tx_q.push_back(rd[1]);
        tx_q.push_back(rd[2]);
        addr_phase({EEW_FIXED_NIBBLE, 3'h5, 1'b1}, 3'b101);
        for (int k = 0; k < 3; k++) begin
            u_eew_bus_master.recv_byte(k < 2, d);
            check("read", {2'h0, rd[k]}, {2'h0, d});
        end
        u_eew_bus_master.stop_cond();
        check("read_stop", 10'h1, {9'h0, standby});
        $display("test read done");
        tx_q.push_back(8'h00);
        addr_phase({EEW_FIXED_NIBBLE, 3'h5, 1'b1}, 3'b101);
        for (int k = 0; k < 3; k++) u_eew_bus_master.bit_cycle(1'b1, ack);
        u_eew_bus_master.recover();
        u_eew_bus_master.send_byte({EEW_FIXED_NIBBLE, 3'h5, 1'b0}, ack);
        u_eew_bus_master.stop_cond();
        check("recovered", 10'h3, {8'h0, ack, standby});
        $display("test recovery done");
        close_out();
    end
endmodule
